// File: pkg/mlt_defines.svh
`ifndef MLT_DEFINES_SVH
`define MLT_DEFINES_SVH

// register byte offsets
`define MLT_OFF_CTRL 12'h000
`define MLT_OFF_CUR_LEVEL 12'h004
`define MLT_OFF_CUR_BAND 12'h008
`define MLT_OFF_VOLT_LEVEL 12'h00c
`define MLT_OFF_VOLT_BAND 12'h010
`define MLT_OFF_METER_LEVEL 12'h014
`define MLT_OFF_METER_BAND 12'h018
`define MLT_OFF_STATUS 12'h01c
`define MLT_OFF_FIRE_COUNT 12'h020

// control field positions
`define MLT_CTRL_CUR_EDGE_LSB 0
`define MLT_CTRL_VOLT_EDGE_LSB 2
`define MLT_CTRL_METER_EDGE_LSB 4
`define MLT_CTRL_SOURCE_BIT 8
`define MLT_CTRL_HOST_FIRE_BIT 9

// reset values
`define MLT_RST_LEVEL 16'h0000
`define MLT_RST_BAND 16'h0000
`define MLT_RST_EDGE 2'h0
`define MLT_RST_SOURCE 1'b0

`endif

// File: pkg/mlt_pkg.sv
package mlt_pkg;

  // edge select codes
  typedef enum logic [1:0] {
    MLT_EDGE_RISE = 2'h0,
    MLT_EDGE_FALL = 2'h1,
    MLT_EDGE_EITHER = 2'h2
  } mlt_edge_e;

  // arm state of one channel, one-hot
  typedef enum logic [2:0] {
    MLT_ST_INSIDE = 3'b001,
    MLT_ST_BELOW = 3'b010,
    MLT_ST_ABOVE = 3'b100
  } mlt_arm_e;

  typedef logic [15:0] mlt_val_t;

  typedef struct packed {
    mlt_val_t [2:0] level;
    mlt_val_t [2:0] band;
    mlt_edge_e [2:0] edge_sel;
    logic source_host;
    mlt_arm_e [2:0] arm;
    logic [2:0] fired;
    logic trig;
    logic [15:0] fire_count;
    logic [2:0] sync0;
    logic [2:0] sync1;
    logic [31:0] prdata;
    logic pslverr;
  } mlt_state_s;

endpackage

// File: hw/mlt_trigger.sv
`timescale 1ns/100ps
`include "mlt_defines.svh"

module mlt_trigger (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample stream, from converter domain
  input wire logic sample_valid,
  input wire logic [15:0] current_sample,
  input wire logic [15:0] voltage_sample,
  input wire logic [15:0] meter_sample,
  // trigger out
  output logic meas_trigger,
  output logic [2:0] channel_fired
);

  mlt_pkg::mlt_state_s st_r;
  mlt_pkg::mlt_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // band limits, upper widened to 17 bits and lower to 18 signed bits so nothing wraps
  function automatic logic [16:0] upper_lim(input logic [15:0] lv, input logic [15:0] bw);
    upper_lim = {1'b0, lv} + {2'b00, bw[15:1]};
  endfunction

  function automatic logic signed [17:0] lower_lim(input logic [15:0] lv,
                                                   input logic [15:0] bw);
    lower_lim = $signed({2'b00, lv}) - $signed({3'b000, bw[15:1]});
  endfunction

  // true for every register offset the bus decodes
  function automatic logic reg_mapped(input logic [11:0] a);
    if (a == `MLT_OFF_CTRL)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_CUR_LEVEL)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_CUR_BAND)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_VOLT_LEVEL)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_VOLT_BAND)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_METER_LEVEL)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_METER_BAND)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_STATUS)
      reg_mapped = 1'b1;
    else if (a == `MLT_OFF_FIRE_COUNT)
      reg_mapped = 1'b1;
    else
      reg_mapped = 1'b0;
  endfunction

  function automatic logic edge_allows(input mlt_pkg::mlt_edge_e sel, input logic rising);
    case (sel)
      mlt_pkg::MLT_EDGE_RISE: edge_allows = rising;
      mlt_pkg::MLT_EDGE_FALL: edge_allows = !rising;
      mlt_pkg::MLT_EDGE_EITHER: edge_allows = 1'b1;
      default: edge_allows = 1'b0;
    endcase
  endfunction

  function automatic mlt_pkg::mlt_edge_e edge_of(input logic [1:0] code);
    if (code == 2'h1)
      edge_of = mlt_pkg::MLT_EDGE_FALL;
    else if (code == 2'h2)
      edge_of = mlt_pkg::MLT_EDGE_EITHER;
    else
      edge_of = mlt_pkg::MLT_EDGE_RISE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample capture, two stages for data from the converter domain

  logic [15:0] samp_s0_r [3];
  logic [15:0] samp_s1_r [3];
  logic [15:0] samp_in [3];

  assign samp_in[0] = current_sample;
  assign samp_in[1] = voltage_sample;
  assign samp_in[2] = meter_sample;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          samp_s0_r[g] <= 16'h0000;
          samp_s1_r[g] <= 16'h0000;
        end
        else
        begin
          samp_s0_r[g] <= samp_in[g];
          samp_s1_r[g] <= samp_s0_r[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // band classification per channel

  logic [2:0] is_above;
  logic [2:0] is_below;
  logic [16:0] up_lim [3];
  logic signed [17:0] lo_lim [3];

  generate
    for (g = 0; g < 3; g++)
    begin : g_cls
      assign up_lim[g] = upper_lim(st_r.level[g], st_r.band[g]);
      assign lo_lim[g] = lower_lim(st_r.level[g], st_r.band[g]);
      assign is_above[g] = {1'b0, samp_s1_r[g]} > up_lim[g];
      assign is_below[g] = $signed({2'b00, samp_s1_r[g]}) < lo_lim[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic access;
  logic setup;
  logic wr;
  logic valid_q;

  assign access = psel && penable;
  assign setup = psel && !penable;
  assign wr = access && pwrite;
  assign valid_q = st_r.sync1[0];

  always_comb
  begin
    logic hit;
    logic any_fire;
    logic host_fire;
    logic [31:0] rd;
    logic mapped;
    hit = 1'b0;
    any_fire = 1'b0;
    host_fire = 1'b0;
    rd = 32'h0000_0000;
    mapped = reg_mapped(paddr);
    st_nxt = st_r;
    st_nxt.fired = 3'b000;
    st_nxt.sync0 = {2'b00, sample_valid};
    st_nxt.sync1 = st_r.sync0;

    // per-channel crossing detection
    for (int c = 0; c < 3; c++)
    begin
      if (valid_q)
      begin
        case (st_r.arm[c])
          mlt_pkg::MLT_ST_BELOW:
          begin
            if (is_above[c])
            begin
              st_nxt.arm[c] = mlt_pkg::MLT_ST_ABOVE;
              hit = edge_allows(st_r.edge_sel[c], 1'b1);
              st_nxt.fired[c] = hit;
            end
          end
          mlt_pkg::MLT_ST_ABOVE:
          begin
            if (is_below[c])
            begin
              st_nxt.arm[c] = mlt_pkg::MLT_ST_BELOW;
              hit = edge_allows(st_r.edge_sel[c], 1'b0);
              st_nxt.fired[c] = hit;
            end
          end
          default:
          begin
            if (is_above[c])
              st_nxt.arm[c] = mlt_pkg::MLT_ST_ABOVE;
            else if (is_below[c])
              st_nxt.arm[c] = mlt_pkg::MLT_ST_BELOW;
          end
        endcase
      end
    end

    // apb register file, read side
    if (paddr == `MLT_OFF_CTRL)
    begin
      rd = {23'h000000, st_r.source_host, 2'h0, st_r.edge_sel[2], st_r.edge_sel[1],
            st_r.edge_sel[0]};
    end
    else if (paddr == `MLT_OFF_CUR_LEVEL)
    begin
      rd = {16'h0000, st_r.level[0]};
    end
    else if (paddr == `MLT_OFF_CUR_BAND)
    begin
      rd = {16'h0000, st_r.band[0]};
    end
    else if (paddr == `MLT_OFF_VOLT_LEVEL)
    begin
      rd = {16'h0000, st_r.level[1]};
    end
    else if (paddr == `MLT_OFF_VOLT_BAND)
    begin
      rd = {16'h0000, st_r.band[1]};
    end
    else if (paddr == `MLT_OFF_METER_LEVEL)
    begin
      rd = {16'h0000, st_r.level[2]};
    end
    else if (paddr == `MLT_OFF_METER_BAND)
    begin
      rd = {16'h0000, st_r.band[2]};
    end
    else if (paddr == `MLT_OFF_STATUS)
    begin
      rd = {23'h000000, st_r.arm[2], st_r.arm[1], st_r.arm[0]};
    end
    else if (paddr == `MLT_OFF_FIRE_COUNT)
    begin
      rd = {16'h0000, st_r.fire_count};
    end
    else
    begin
      rd = 32'h0000_0000;
    end

    // apb register file, write side
    if (wr && mapped && pstrb[0] && paddr == `MLT_OFF_CTRL)
    begin
      st_nxt.edge_sel[0] = edge_of(pwdata[`MLT_CTRL_CUR_EDGE_LSB +: 2]);
      st_nxt.edge_sel[1] = edge_of(pwdata[`MLT_CTRL_VOLT_EDGE_LSB +: 2]);
      st_nxt.edge_sel[2] = edge_of(pwdata[`MLT_CTRL_METER_EDGE_LSB +: 2]);
    end
    if (wr && pstrb[1] && paddr == `MLT_OFF_CTRL)
    begin
      st_nxt.source_host = pwdata[`MLT_CTRL_SOURCE_BIT];
      host_fire = pwdata[`MLT_CTRL_HOST_FIRE_BIT] && st_r.source_host;
    end
    for (int c = 0; c < 3; c++)
    begin
      if (wr && paddr == 12'(`MLT_OFF_CUR_LEVEL + 8 * c))
      begin
        if (pstrb[0])
        begin
          st_nxt.level[c][7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
          st_nxt.level[c][15:8] = pwdata[15:8];
        end
      end
      if (wr && paddr == 12'(`MLT_OFF_CUR_BAND + 8 * c))
      begin
        if (pstrb[0])
        begin
          st_nxt.band[c][7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
          st_nxt.band[c][15:8] = pwdata[15:8];
        end
      end
    end

    any_fire = |st_nxt.fired;
    // internal source only; host source bypasses the level detector
    st_nxt.trig = st_r.source_host ? host_fire : any_fire;
    if (st_nxt.trig)
      st_nxt.fire_count = st_r.fire_count + 16'h0001;
    // read data captured in setup so it stands through the access phase
    st_nxt.prdata = (setup && !pwrite) ? rd : st_r.prdata;
    st_nxt.pslverr = access && !mapped;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.level <= {3{`MLT_RST_LEVEL}};
      st_r.band <= {3{`MLT_RST_BAND}};
      st_r.edge_sel[0] <= mlt_pkg::MLT_EDGE_RISE;
      st_r.edge_sel[1] <= mlt_pkg::MLT_EDGE_RISE;
      st_r.edge_sel[2] <= mlt_pkg::MLT_EDGE_RISE;
      st_r.source_host <= `MLT_RST_SOURCE;
      st_r.arm[0] <= mlt_pkg::MLT_ST_INSIDE;
      st_r.arm[1] <= mlt_pkg::MLT_ST_INSIDE;
      st_r.arm[2] <= mlt_pkg::MLT_ST_INSIDE;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready = 1'b1;
  assign prdata = st_r.prdata;
  // error only while an access to an undecoded offset is on the bus
  assign pslverr = access && !reg_mapped(paddr);
  assign meas_trigger = st_r.trig;
  assign channel_fired = st_r.fired;

endmodule

// File: verif/mlt_sample_src.sv
`timescale 1ns/100ps
// converter model: one value on all three channels, held between valid strobes
module mlt_sample_src (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bench control
  input wire logic slow,
  input wire logic [15:0] target,
  // sample stream
  output logic sample_valid,
  output logic [15:0] current_sample,
  output logic [15:0] voltage_sample,
  output logic [15:0] meter_sample
);
  logic [1:0] gap_r;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      gap_r <= 2'h0;
      sample_valid <= 1'b0;
      current_sample <= 16'h0000;
    end
    else
    begin
      gap_r <= gap_r + 2'h1;
      sample_valid <= !slow || gap_r == 2'h0;
      if (!slow || gap_r == 2'h0)
        current_sample <= target;
    end
  end
  assign voltage_sample = current_sample;
  assign meter_sample = current_sample;
endmodule

// File: verif/mlt_trigger_properties.sv
`timescale 1ns/100ps
module mlt_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus and samples
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] current_sample,
  // triggers
  input wire logic meas_trigger,
  input wire logic [2:0] channel_fired
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence acc_s;
    psel && penable;
  endsequence
  sequence quiet_s;
    (!psel && $stable(current_sample))[*8];
  endsequence
  ready_tied_a: assert property (pready) else $error("pready low");
  err_map_a: assert property (acc_s |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h020))
    else $error("bad err");
  err_idle_a: assert property (!penable |-> !pslverr) else $error("err outside access");
  trig_pulse_a: assert property (meas_trigger |=> !meas_trigger) else $error("long trig");
  cur_pulse_a: assert property (channel_fired[0] |=> !channel_fired[0]) else $error("cur");
  volt_pulse_a: assert property (channel_fired[1] |=> !channel_fired[1]) else $error("volt");
  meter_pulse_a: assert property (channel_fired[2] |=> !channel_fired[2]) else $error("mtr");
  cur_quiet_a: assert property (quiet_s |-> !channel_fired[0]) else $error("no cause");
endmodule
bind mlt_trigger mlt_checker i_mlt_checker (.clk_sys, .reset, .psel, .penable, .paddr,
  .pready, .pslverr, .current_sample, .meas_trigger, .channel_fired);

// File: verif/test_measurement_level_trigger.sv
`timescale 1ns/100ps
module test_measurement_level_trigger;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic got_err;
  logic slow = 1'b0;
  logic [15:0] target = 16'h0000;
  logic sample_valid;
  logic [15:0] current_sample;
  logic [15:0] voltage_sample;
  logic [15:0] meter_sample;
  logic meas_trigger;
  logic [2:0] channel_fired;
  int bad_count = 0;
  int tests_run = 0;
  int fire_cnt [3] = '{0, 0, 0};
  int meas_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  mlt_sample_src i_mlt_sample_src (.clk_sys, .reset, .slow, .target, .sample_valid,
    .current_sample, .voltage_sample, .meter_sample);
  mlt_trigger i_mlt_trigger (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'h3), .prdata, .pready, .pslverr, .sample_valid, .current_sample,
    .voltage_sample, .meter_sample, .meas_trigger, .channel_fired);
  always @(posedge clk_sys)
  begin
    meas_cnt += meas_trigger;
    for (int i = 0; i < 3; i++)
      fire_cnt[i] += channel_fired[i];
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (!pready && n < 16)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 16)
    begin
      bad_count++;
      stop_test();
    end
    got_err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // new sample value, then check channel and trigger pulse counts (ef below zero: channel pulses not checked)
  task automatic step(input logic [15:0] v, input int ef, input int em);
    int s [3];
    int m;
    s = fire_cnt;
    m = meas_cnt;
    target <= v;
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < 3; i++)
      if (ef >= 0)
        chk(fire_cnt[i] - s[i], ef);
    chk(meas_cnt - m, em);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    int m;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 28; a += 4)
    begin
      apb(1'b0, a[11:0], 32'h0, r);
      chk(r, 32'h0);
    end
    apb(1'b0, 12'h040, 32'h0, r);
    chk({31'h0, got_err}, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h004 + 12'(8 * i), 32'h64, r);
      apb(1'b1, 12'h008 + 12'(8 * i), 32'h28, r);
      apb(1'b0, 12'h004 + 12'(8 * i), 32'h0, r);
      chk(r, 32'h64);
    end
    step(16'h0032, 0, 0);
    step(16'h0078, 0, 0);
    step(16'h0079, 1, 1);
    step(16'h0032, 0, 0);
    slow <= 1'b1;
    step(16'h0079, 1, 1);
    apb(1'b1, 12'h000, 32'h15, r);
    step(16'h0050, 0, 0);
    step(16'h004f, 1, 1);
    step(16'h0079, 0, 0);
    apb(1'b1, 12'h000, 32'h2a, r);
    step(16'h004f, 1, 1);
    step(16'h0064, 0, 0);
    step(16'h004f, 0, 0);
    step(16'h0079, 1, 1);
    apb(1'b1, 12'h000, 32'h12a, r);
    step(16'h004f, -1, 0);
    m = meas_cnt;
    apb(1'b1, 12'h000, 32'h32a, r);
    repeat (8) @(posedge clk_sys);
    chk(meas_cnt - m, 1);
    stop_test();
  end
endmodule
